// ---- rtl/mwss_pkg.sv ----
// constants, modes and carrier types of the microwire frame sequencer
// assumes a 100 MHz system clock; the serial clock is divided down from it
package mwss_pkg;
    // timing: serial clock period as generated on the pin, and the system clock
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned SCLK_PERIOD_NS = 80;
    // half serial period in system cycles, rounded down, never below one
    localparam int unsigned HALF_CYCLES_RAW = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned HALF_CYCLES     = (HALF_CYCLES_RAW < 1) ? 1 : HALF_CYCLES_RAW;
    localparam logic [3:0]  HALF_LAST       = 4'(HALF_CYCLES - 1);

    // frame layout
    localparam int unsigned CTRL_BITS     = 8;
    localparam logic [3:0]  CTRL_LAST_BIT = 4'h7;
    localparam logic [3:0]  SIZE_MIN_M1   = 4'h3; // 4-bit word, coded as size minus one
    localparam int unsigned RX_WIDTH      = 16;

    // reset values
    localparam logic [RX_WIDTH-1:0] RX_RESET   = 16'h0000;
    localparam logic [7:0]          CTRL_RESET = 8'h00;

    typedef enum logic [2:0] {
        MWSS_IDLE  = 3'b000,
        MWSS_CTRL  = 3'b001,
        MWSS_WAIT  = 3'b010,
        MWSS_REPLY = 3'b011,
        MWSS_TAIL  = 3'b100
    } mwss_state_t;

    // levels driven onto the link pins
    typedef struct packed {
        logic sclk;
        logic fss;
        logic sdo;
        logic sdo_oe;
    } mwss_pins_t;

    localparam mwss_pins_t PINS_IDLE = '{sclk: 1'b0, fss: 1'b1, sdo: 1'b0, sdo_oe: 1'b0};

    // one received word toward the receive fifo
    typedef struct packed {
        logic                valid;
        logic [RX_WIDTH-1:0] data;
    } mwss_rx_t;
endpackage

// ---- rtl/mwss_sync2.sv ----
// two-stage synchroniser for one level arriving from outside the clock domain
// assumes the level is stable for several system clocks between changes
`timescale 1ns/1ps
`default_nettype none
module mwss_sync2 (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;
    logic sync_q;

    // first stage is read only by the second stage
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// ---- rtl/mwss_master.sv ----
// microwire frame sequencer of the sync serial port, master role
// assumes a transmit fifo with valid/ready on the same clock and a receive fifo that never stalls
// Operation
// - idle holds serial clock low, frame select high, data out low.
// - each frame opens with an 8-bit control word, half-duplex.
// - no input data is captured while the control word shifts out.
// - a control byte in the transmit fifo while enabled starts a frame.
// - frame select falling loads oldest fifo entry, drives its msb out.
// - frame select stays low in control phase; slave leaves data-in undriven.
// - reply bits are sampled on serial clock rising edges.
// - single frame: frame select rises one period after last bit, word pushed.
// - continuous frames keep frame select low and run back to back.
// - next control byte follows the last reply bit with no gap.
// - continuous: word pushed on falling edge after its last bit.
// - with transmit disabled the data output is not driven.
// - role is fixed by configuration; no switching during operation.
// - words shift msb first; size 4 to 16 bits.
`timescale 1ns/1ps
`default_nettype none
module mwss_master
    import mwss_pkg::*;
(
    input  wire logic                I_CLK,
    input  wire logic                I_RSTN,
    input  wire logic                I_ENABLE,
    input  wire logic                I_TX_ENABLE,
    input  wire logic                I_MASTER,
    input  wire logic [3:0]          I_DATA_SIZE,
    input  wire logic                I_TX_VALID,
    input  wire logic [7:0]          I_TX_DATA,
    input  wire logic                I_SDI,
    output logic                     O_TX_READY,
    output logic                     O_RX_VALID,
    output logic [RX_WIDTH-1:0]      O_RX_DATA,
    output logic                     O_SCLK,
    output logic                     O_FSS,
    output logic                     O_SDO,
    output logic                     O_SDO_OE
);
    mwss_state_t         state_q, state_d;
    mwss_pins_t          pins_q, pins_d;
    mwss_rx_t            rx_q, rx_d;
    logic [3:0]          div_q, div_d;
    logic [3:0]          bit_q, bit_d;
    logic [3:0]          size_q, size_d;
    logic [7:0]          ctrl_q, ctrl_d;
    logic [RX_WIDTH-1:0] sh_q, sh_d;
    logic                pop_q, pop_d;
    logic                role_q, role_d;
    logic                role_ok_q, role_ok_d;
    logic                sdi_s;
    logic                tick;
    logic                start_ok;
    logic [3:0]          size_req;

    // data-in comes from the pin, so it is synchronised before use
    mwss_sync2 u_sdi_sync (
        .i_clk   (I_CLK),
        .i_rstn  (I_RSTN),
        .i_async (I_SDI),
        .o_sync  (sdi_s)
    );

    // half-period tick of the generated serial clock
    assign tick     = (div_q == HALF_LAST);
    // requests below the minimum size are widened to four bits
    assign size_req = (I_DATA_SIZE < SIZE_MIN_M1) ? SIZE_MIN_M1 : I_DATA_SIZE;
    assign start_ok = I_ENABLE && role_q && role_ok_q && I_TX_VALID;

    // role is caught once after reset release and then held
    always_comb begin
        role_d    = role_q;
        role_ok_d = 1'b1;
        if (!role_ok_q) begin
            role_d = I_MASTER;
        end
    end

    // frame sequencer: next state, pins, shifters and fifo strobes
    always_comb begin
        state_d        = state_q;
        pins_d         = pins_q;
        pins_d.sdo_oe  = I_TX_ENABLE;
        rx_d           = rx_q;
        rx_d.valid     = 1'b0;
        div_d          = tick ? 4'h0 : div_q + 4'h1;
        bit_d          = bit_q;
        size_d         = size_q;
        ctrl_d         = ctrl_q;
        sh_d           = sh_q;
        pop_d          = 1'b0;
        unique case (state_q)
            MWSS_IDLE: begin
                div_d       = 4'h0;
                pins_d.sclk = 1'b0;
                pins_d.fss  = 1'b1;
                pins_d.sdo  = 1'b0;
                if (start_ok) begin
                    ctrl_d      = I_TX_DATA;
                    pop_d       = 1'b1;
                    pins_d.fss  = 1'b0;
                    pins_d.sdo  = I_TX_DATA[CTRL_LAST_BIT[2:0]];
                    bit_d       = CTRL_LAST_BIT;
                    state_d     = MWSS_CTRL;
                end
            end
            MWSS_CTRL: begin
                // the receive shifter is left alone in this phase
                if (tick) begin
                    pins_d.sclk = ~pins_q.sclk;
                    if (pins_q.sclk) begin
                        if (bit_q == 4'h0) begin
                            pins_d.sdo = 1'b0;
                            state_d    = MWSS_WAIT;
                        end else begin
                            bit_d      = bit_q - 4'h1;
                            pins_d.sdo = ctrl_q[3'(bit_q - 4'h1)];
                        end
                    end
                end
            end
            MWSS_WAIT: begin
                // one clock for the slave to decode the control word
                if (tick) begin
                    pins_d.sclk = ~pins_q.sclk;
                    if (pins_q.sclk) begin
                        bit_d   = size_req;
                        size_d  = size_req;
                        sh_d    = RX_RESET;
                        state_d = MWSS_REPLY;
                    end
                end
            end
            MWSS_REPLY: begin
                if (tick) begin
                    pins_d.sclk = ~pins_q.sclk;
                    if (!pins_q.sclk) begin
                        sh_d = {sh_q[RX_WIDTH-2:0], sdi_s};
                    end else if (bit_q != 4'h0) begin
                        bit_d = bit_q - 4'h1;
                    end else if (start_ok) begin
                        // back to back: push word and open next control word now
                        rx_d.valid = 1'b1;
                        rx_d.data  = sh_q;
                        ctrl_d     = I_TX_DATA;
                        pop_d      = 1'b1;
                        pins_d.sdo = I_TX_DATA[CTRL_LAST_BIT[2:0]];
                        bit_d      = CTRL_LAST_BIT;
                        state_d    = MWSS_CTRL;
                    end else begin
                        state_d = MWSS_TAIL;
                    end
                end
            end
            MWSS_TAIL: begin
                // clock stays low; frame select rises a full period after the last sample
                if (tick) begin
                    pins_d.fss = 1'b1;
                    rx_d.valid = 1'b1;
                    rx_d.data  = sh_q;
                    state_d    = MWSS_IDLE;
                end
            end
            default: begin
                state_d = MWSS_IDLE;
            end
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            state_q   <= MWSS_IDLE;
            pins_q    <= PINS_IDLE;
            rx_q      <= '{valid: 1'b0, data: RX_RESET};
            div_q     <= 4'h0;
            bit_q     <= 4'h0;
            size_q    <= SIZE_MIN_M1;
            ctrl_q    <= CTRL_RESET;
            sh_q      <= RX_RESET;
            pop_q     <= 1'b0;
            role_q    <= 1'b0;
            role_ok_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            pins_q    <= pins_d;
            rx_q      <= rx_d;
            div_q     <= div_d;
            bit_q     <= bit_d;
            size_q    <= size_d;
            ctrl_q    <= ctrl_d;
            sh_q      <= sh_d;
            pop_q     <= pop_d;
            role_q    <= role_d;
            role_ok_q <= role_ok_d;
        end
    end

    // outputs are the flops themselves
    assign O_TX_READY = pop_q;
    assign O_RX_VALID = rx_q.valid;
    assign O_RX_DATA  = rx_q.data;
    assign O_SCLK     = pins_q.sclk;
    assign O_FSS      = pins_q.fss;
    assign O_SDO      = pins_q.sdo;
    assign O_SDO_OE   = pins_q.sdo_oe;

    // helper: rising serial clock edges counted within the current phase
    logic [4:0] rise_cnt_q;
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN || state_d != state_q) begin
            rise_cnt_q <= 5'h00;
        end else if (tick && !pins_q.sclk && state_q != MWSS_TAIL) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end

    property p_idle_levels;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_IDLE && $past(state_q) == MWSS_IDLE)
            |-> (!O_SCLK && O_FSS && !O_SDO);
    endproperty
    a_idle_levels: assert property (p_idle_levels) else $error("idle pin levels wrong");

    property p_ctrl_eight;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_CTRL && state_d == MWSS_WAIT) |-> (rise_cnt_q == 5'h08);
    endproperty
    a_ctrl_eight: assert property (p_ctrl_eight) else $error("control word not 8 clocks");

    property p_no_capture;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_CTRL && $past(state_q) == MWSS_CTRL) |-> $stable(sh_q);
    endproperty
    a_no_capture: assert property (p_no_capture) else $error("capture during control word");

    property p_start;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_IDLE && start_ok) |=> (state_q == MWSS_CTRL && O_TX_READY);
    endproperty
    a_start: assert property (p_start) else $error("frame did not start");

    property p_load_msb;
        @(posedge I_CLK) disable iff (!I_RSTN)
        O_TX_READY |-> (!O_FSS && O_SDO == ctrl_q[7] && ctrl_q == $past(I_TX_DATA));
    endproperty
    a_load_msb: assert property (p_load_msb) else $error("control msb not driven");

    property p_fss_low;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_CTRL || state_q == MWSS_WAIT || state_q == MWSS_REPLY) |-> !O_FSS;
    endproperty
    a_fss_low: assert property (p_fss_low) else $error("frame select high mid frame");

    property p_sample;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_REPLY && tick && !O_SCLK) |=> (O_SCLK && sh_q[0] == $past(sdi_s));
    endproperty
    a_sample: assert property (p_sample) else $error("reply bit not sampled on rise");

    property p_single_end;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_REPLY && state_d == MWSS_TAIL) |=> (!O_FSS && !O_SCLK) [*4] ##1
            (O_FSS && O_RX_VALID && !O_SCLK);
    endproperty
    a_single_end: assert property (p_single_end) else $error("single frame end timing");

    property p_back_to_back;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_REPLY && state_d == MWSS_CTRL) |=> (!O_FSS && O_RX_VALID && O_TX_READY);
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("continuous handover broken");

    property p_oe;
        @(posedge I_CLK) disable iff (!I_RSTN)
        !I_TX_ENABLE |=> !O_SDO_OE;
    endproperty
    a_oe: assert property (p_oe) else $error("data out driven while disabled");

    property p_role;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (role_ok_q && !role_q) |-> (state_q == MWSS_IDLE && $stable(role_q));
    endproperty
    a_role: assert property (p_role) else $error("frame ran without master role");

    property p_reply_len;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (state_q == MWSS_REPLY && state_d != MWSS_REPLY)
            |-> (rise_cnt_q == {1'b0, size_q} + 5'h01);
    endproperty
    a_reply_len: assert property (p_reply_len) else $error("reply length mismatch");
endmodule
`default_nettype wire

// ---- verif/mwss_slave_model.sv ----
// behavioural microwire slave on the far side of the serial pins
// assumes the master makes the serial clock; the reply is derived from the control byte
`timescale 1ns/1ps
`default_nettype none
module mwss_slave_model (
    input  wire logic       i_sclk,
    input  wire logic       i_fss,
    input  wire logic       i_sdo,
    input  wire logic [3:0] i_size,
    output logic            o_sdi,
    output logic [7:0]      o_ctrl,
    output logic            o_ctrl_stb
);
    int          cnt;
    int          n;
    logic [7:0]  shreg;
    logic [15:0] reply;

    initial begin
        cnt        = 0;
        n          = 4;
        shreg      = 8'h00;
        reply      = 16'h0000;
        o_sdi      = 1'b0;
        o_ctrl     = 8'h00;
        o_ctrl_stb = 1'b0;
    end

    // control bits captured on rising edges, then decode clock, then reply
    always @(posedge i_sclk) begin
        if (!i_fss) begin
            if (cnt < 8) begin
                shreg = {shreg[6:0], i_sdo};
            end
            cnt = cnt + 1;
            if (cnt == 8) begin
                o_ctrl     = shreg;
                reply      = {shreg, shreg ^ 8'hA5};
                n          = (i_size < 4'h3) ? 4 : int'(i_size) + 1;
                o_ctrl_stb = 1'b1;
            end
        end
    end

    // reply bits launched on falling edges; otherwise the line flips like a floating wire
    always @(negedge i_sclk) begin
        o_ctrl_stb = 1'b0;
        if (cnt >= 9 && cnt < 9 + n) begin
            o_sdi = reply[n - 1 - (cnt - 9)];
        end else begin
            o_sdi = ~o_sdi;
        end
        if (cnt == 9 + n) begin
            cnt = 0;
        end
    end

    // frame end releases the line
    always @(posedge i_fss) begin
        cnt   = 0;
        o_sdi = ~o_sdi;
    end
endmodule
`default_nettype wire

// ---- verif/sync_serial_microwire_frame_test.sv ----
// self-checking bench of the microwire master with a slave model on the pins
// assumes a 100 MHz system clock and a transmit fifo played by the bench
`timescale 1ns/1ps
`default_nettype none
module sync_serial_microwire_frame_test;
    import mwss_pkg::*;
    logic I_CLK = 1'b0, I_RSTN = 1'b0, I_ENABLE = 1'b1, I_TX_ENABLE = 1'b1, I_MASTER = 1'b1;
    logic [3:0] I_DATA_SIZE = 4'h3;
    logic I_TX_VALID = 1'b0;
    logic [7:0] I_TX_DATA = 8'h00;
    logic I_SDI, O_TX_READY, O_RX_VALID, O_SCLK, O_FSS, O_SDO, O_SDO_OE, ctrl_stb;
    logic [RX_WIDTH-1:0] O_RX_DATA;
    logic [7:0] ctrl_seen;
    logic [31:0] seed = 32'h1;
    logic [7:0] exp_ctrl[$];
    logic [15:0] exp_rx[$];
    int miscompares = 0, compares = 0, cyc = 0, fss_rises = 0;
    logic fss_prev = 1'b1;
    wire sdo_pin = O_SDO_OE ? O_SDO : 1'b0; // pull-down when undriven

    mwss_master DUT (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ENABLE(I_ENABLE),
        .I_TX_ENABLE(I_TX_ENABLE), .I_MASTER(I_MASTER), .I_DATA_SIZE(I_DATA_SIZE),
        .I_TX_VALID(I_TX_VALID), .I_TX_DATA(I_TX_DATA), .I_SDI(I_SDI),
        .O_TX_READY(O_TX_READY), .O_RX_VALID(O_RX_VALID), .O_RX_DATA(O_RX_DATA),
        .O_SCLK(O_SCLK), .O_FSS(O_FSS), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE));
    mwss_slave_model slave (.i_sclk(O_SCLK), .i_fss(O_FSS), .i_sdo(sdo_pin),
        .i_size(I_DATA_SIZE), .o_sdi(I_SDI), .o_ctrl(ctrl_seen), .o_ctrl_stb(ctrl_stb));

    initial begin
        forever #5 I_CLK = ~I_CLK;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic bit bad(input bit c);
        compares++;
        return c;
    endfunction

    task automatic fail(input string msg);
        miscompares++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic summarize();
        if (miscompares == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // inputs move a fixed 1 ns after each rising edge
    task automatic step();
        @(posedge I_CLK);
        #1;
        cyc++;
    endtask

    task automatic wait_ready(input int bound);
        int i;
        for (i = 0; i < bound && O_TX_READY !== 1'b1; i++) step();
        if (O_TX_READY !== 1'b1) begin
            fail("no transmit pop");
            summarize();
        end
    endtask

    // k back-to-back frames of one reply size; checks framing length and pin levels
    task automatic run_frames(input int k, input logic [3:0] size);
        int f, t0, nb, i;
        logic [7:0] b, c;
        nb = (size < 4'h3) ? 4 : int'(size) + 1;
        I_DATA_SIZE = size;
        I_TX_VALID = 1'b1;
        for (f = 0; f < k; f++) begin
            seed = xorshift(seed);
            b = seed[7:0];
            c = I_TX_ENABLE ? b : 8'h00;
            exp_ctrl.push_back(c);
            exp_rx.push_back({c, c ^ 8'hA5} & 16'((32'h1 << nb) - 1));
            I_TX_DATA = b;
            wait_ready(300);
            if (f == 0) t0 = cyc;
            if (bad(O_FSS !== 1'b0)) fail("frame select not low at start");
            if (bad(O_SDO_OE !== I_TX_ENABLE)) fail("output enable wrong");
            step();
        end
        I_TX_VALID = 1'b0;
        i = fss_rises;
        while (O_FSS !== 1'b1 && cyc - t0 < k * 210 + 20) step();
        if (O_FSS !== 1'b1) begin
            fail("frame select stuck low");
            summarize();
        end
        if (bad(cyc - t0 !== k * 8 * (9 + nb) + 4)) fail("frame length wrong");
        if (bad({O_SCLK, O_SDO} !== 2'b00)) fail("idle levels wrong");
        // the rise counter updates one edge after frame select is seen high
        step();
        if (bad(fss_rises - i !== 1)) fail("frame select rose inside run");
        repeat (5) step();
    endtask

    // result checker: oldest note against each control byte and received word
    always @(posedge ctrl_stb) begin
        if (bad(exp_ctrl.size() == 0)) fail("unexpected control byte");
        else if (bad(ctrl_seen !== exp_ctrl.pop_front())) fail("control byte wrong");
    end
    always @(posedge I_CLK) begin
        if (O_FSS === 1'b1 && fss_prev === 1'b0) fss_rises <= fss_rises + 1;
        fss_prev <= O_FSS;
        if (O_RX_VALID === 1'b1) begin
            if (bad(exp_rx.size() == 0)) fail("unexpected receive push");
            else if (bad(O_RX_DATA !== exp_rx[0])) fail("word wrong");
            if (exp_rx.size() != 0) void'(exp_rx.pop_front());
        end
    end

    initial begin
        int s;
        repeat (4) step();
        if (bad({O_SCLK, O_FSS, O_SDO, O_SDO_OE} !== 4'b0100)) fail("reset levels wrong");
        I_RSTN = 1'b1;
        step();
        // output enable follows transmit enable one edge after release
        if (bad({O_SCLK, O_FSS, O_SDO, O_SDO_OE} !== 4'b0101)) fail("released levels wrong");
        for (s = 0; s < 16; s++) run_frames(1, 4'(s));
        run_frames(3, 4'h5);
        run_frames(2, 4'hF);
        I_TX_ENABLE = 1'b0;
        run_frames(1, 4'h7);
        I_TX_ENABLE = 1'b1;
        I_ENABLE = 1'b0;
        I_TX_VALID = 1'b1;
        for (s = 0; s < 100; s++) begin
            step();
            if (bad(O_FSS !== 1'b1 || O_TX_READY !== 1'b0)) fail("started while disabled");
        end
        I_ENABLE = 1'b1;
        I_RSTN = 1'b0;
        I_MASTER = 1'b0;
        repeat (4) step();
        I_RSTN = 1'b1;
        step();
        I_MASTER = 1'b1;
        for (s = 0; s < 100; s++) begin
            step();
            if (bad(O_FSS !== 1'b1 || O_SCLK !== 1'b0)) fail("role changed after reset");
        end
        I_TX_VALID = 1'b0;
        if (bad(exp_rx.size() != 0 || exp_ctrl.size() != 0)) fail("results missing");
        summarize();
    end
endmodule
`default_nettype wire
